/* File: dids_pkg.sv */
// constants for the identification and status register bank
// assumes register commands are already decoded from the serial link
package dids_pkg;
   // register addresses
   localparam logic [7:0] ADDR_IDENTITY = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h01;
   // reset value of the status register
   localparam logic [7:0] STATUS_RESET  = 8'h80;
   // status field positions
   localparam int POS_POWER_ON_FLAG     = 7;
   localparam int POS_NOT_READY         = 6;
   localparam int POS_POS_TOP_RAIL      = 5;
   localparam int POS_POS_BOTTOM_RAIL   = 4;
   localparam int POS_NEG_TOP_RAIL      = 3;
   localparam int POS_NEG_BOTTOM_RAIL   = 2;
   localparam int POS_REF_LOW_THIRD     = 1;
   localparam int POS_REF_ABSENT        = 0;
   // identification fields, value arbitrary
   localparam logic [2:0] MODEL_ID_DEFAULT = 3'h6;
   // reserved upper identity bits, value arbitrary
   localparam logic [4:0] ID_RESERVED_VAL  = 5'h00;
   // monitor vector width, one bit per status flag 5..0
   localparam int MON_W = 6;
   // monitor flag reset value
   localparam logic [5:0] MON_RESET = 6'h00;
endpackage : dids_pkg

/* File: dids_regs.sv */
// identification and status registers of the converter
// assumes monitor comparators are asynchronous and enables come from config logic
module dids_regs
   import dids_pkg::*;
#(
   parameter logic [2:0] MODEL_IDENTIFIER = MODEL_ID_DEFAULT
)
(
   // clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   // decoded register commands
   input  wire logic       i_register_read_command,
   input  wire logic       i_register_write_command,
   input  wire logic [7:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   // device events
   input  wire logic       i_por_event,
   input  wire logic       i_startup_done,
   // analog monitor comparators, asynchronous
   input  wire logic       i_pos_out_near_top_rail,
   input  wire logic       i_pos_out_near_bottom_rail,
   input  wire logic       i_neg_out_near_top_rail,
   input  wire logic       i_neg_out_near_bottom_rail,
   input  wire logic       i_reference_low_third,
   input  wire logic       i_reference_absent,
   // monitor enables
   input  wire logic       i_rail_monitor_enable,
   input  wire logic [1:0] i_reference_monitor_enable,
   // read answer
   output logic [7:0]      o_reg_rdata,
   output logic            o_reg_rvalid,
   // flag copy for the rest of the device
   output logic            o_power_on_flag
);

   typedef struct packed {
      logic [MON_W-1:0] sync1;
      logic [MON_W-1:0] sync2;
      logic [MON_W-1:0] sync3;
      logic [MON_W-1:0] mon;
      logic             power_on_flag;
      logic [7:0]       rdata;
      logic             rvalid;
   } dids_state_t;

   dids_state_t      state;
   dids_state_t      next_state;
   logic             rst_meta;
   logic             rst_sync;
   logic [MON_W-1:0] mon_raw;
   logic [MON_W-1:0] mon_mask;
   logic [7:0]       status_value;
   logic [7:0]       identity_value;
   logic             status_write;
   logic             por_clear;

   // reset release through two flops
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // monitor inputs in status bit order, and their enable mask
   assign mon_raw  = {i_pos_out_near_top_rail, i_pos_out_near_bottom_rail,
                      i_neg_out_near_top_rail, i_neg_out_near_bottom_rail,
                      i_reference_low_third, i_reference_absent};
   assign mon_mask = {{4{i_rail_monitor_enable}},
                      i_reference_monitor_enable[1],
                      i_reference_monitor_enable[0]};

   // register views
   always_comb
   begin
      identity_value = {ID_RESERVED_VAL, MODEL_IDENTIFIER};
      status_value   = 8'h00;
      status_value[POS_POWER_ON_FLAG] = state.power_on_flag;
      status_value[POS_NOT_READY]     = ~i_startup_done;
      status_value[POS_POS_TOP_RAIL]    = state.mon[POS_POS_TOP_RAIL];
      status_value[POS_POS_BOTTOM_RAIL] = state.mon[POS_POS_BOTTOM_RAIL];
      status_value[POS_NEG_TOP_RAIL]    = state.mon[POS_NEG_TOP_RAIL];
      status_value[POS_NEG_BOTTOM_RAIL] = state.mon[POS_NEG_BOTTOM_RAIL];
      status_value[POS_REF_LOW_THIRD]   = state.mon[POS_REF_LOW_THIRD];
      status_value[POS_REF_ABSENT]      = state.mon[POS_REF_ABSENT];
   end

   // write decode: only the flag bit of status is writable
   assign status_write = i_register_write_command && (i_reg_addr == ADDR_STATUS);
   assign por_clear    = status_write && !i_reg_wdata[POS_POWER_ON_FLAG];

   // next state
   always_comb
   begin
      next_state       = state;
      next_state.sync1 = mon_raw;
      next_state.sync2 = state.sync1;
      next_state.sync3 = state.sync2;
      // accept a change once the later stages agree, then gate
      for (int i = 0; i < MON_W; i++)
      begin
         if (state.sync2[i] == state.sync3[i])
         begin
            next_state.mon[i] = state.sync3[i] & mon_mask[i];
         end
         else
         begin
            next_state.mon[i] = state.mon[i] & mon_mask[i];
         end
      end
      // set wins over clear
      if (i_por_event)
      begin
         next_state.power_on_flag = 1'b1;
      end
      else if (por_clear)
      begin
         next_state.power_on_flag = 1'b0;
      end
      // read answer one cycle after the command
      next_state.rvalid = i_register_read_command;
      if (i_register_read_command)
      begin
         case (i_reg_addr)
            ADDR_IDENTITY: next_state.rdata = identity_value;
            ADDR_STATUS:   next_state.rdata = status_value;
            default:       next_state.rdata = 8'h00;
         endcase
      end
   end

   // state register
   always_ff @(posedge i_clk_sys or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         state               <= '0;
         state.sync1         <= MON_RESET;
         state.sync2         <= MON_RESET;
         state.sync3         <= MON_RESET;
         state.mon           <= MON_RESET;
         state.power_on_flag <= STATUS_RESET[POS_POWER_ON_FLAG];
      end
      else
      begin
         state <= next_state;
      end
   end

   // outputs
   assign o_reg_rdata     = state.rdata;
   assign o_reg_rvalid    = state.rvalid;
   assign o_power_on_flag = state.power_on_flag;

   // checks
   a_por_clear: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
      (por_clear && !i_por_event) |=> !o_power_on_flag)
      else $error("flag not cleared by write of zero");
   a_por_hold: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
      (o_power_on_flag && !por_clear) |=> o_power_on_flag)
      else $error("flag dropped without clear");
   a_por_rise_cause: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
      $rose(o_power_on_flag) |-> $past(i_por_event))
      else $error("flag set without event");
   a_reset_value: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
      $rose(rst_sync) |-> (o_power_on_flag && status_value[5:0] == 6'h00))
      else $error("status reset value wrong");
   a_ready_read: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
      (i_register_read_command && i_reg_addr == ADDR_STATUS)
      |=> (o_reg_rvalid && o_reg_rdata[6] == !$past(i_startup_done)))
      else $error("ready bit wrong");
   a_id_model: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
      (i_register_read_command && i_reg_addr == ADDR_IDENTITY)
      |=> o_reg_rdata[2:0] == MODEL_IDENTIFIER)
      else $error("model identifier wrong");
   a_id_reserved: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
      (i_register_read_command && i_reg_addr == ADDR_IDENTITY)
      |=> o_reg_rdata[7:3] == ID_RESERVED_VAL)
      else $error("reserved identity bits changed");
   a_rail_gate: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
      (!i_rail_monitor_enable)[*2] |-> status_value[5:2] == 4'h0)
      else $error("rail flag shown while disabled");
   a_ref_gate: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
      (i_reference_monitor_enable == 2'h0)[*2] |-> status_value[1:0] == 2'h0)
      else $error("reference flag shown while disabled");
   a_pos_top: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
      (i_pos_out_near_top_rail && i_rail_monitor_enable)[*4] |=> status_value[5])
      else $error("positive top rail flag missed");
   a_pos_bottom: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
      (i_pos_out_near_bottom_rail && i_rail_monitor_enable)[*4] |=> status_value[4])
      else $error("positive bottom rail flag missed");
   a_neg_top: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
      (!i_neg_out_near_top_rail)[*4] |=> !status_value[3])
      else $error("negative top rail flag stuck");
   a_neg_bottom: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
      (i_neg_out_near_bottom_rail && i_rail_monitor_enable)[*4] |=> status_value[2])
      else $error("negative bottom rail flag missed");
   a_ref_third: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
      (i_reference_low_third && i_reference_monitor_enable[1])[*4] |=> status_value[1])
      else $error("reference third flag missed");
   a_ref_absent: assert property (@(posedge i_clk_sys) disable iff (!rst_sync)
      (!i_reference_absent)[*4] |=> !status_value[0])
      else $error("reference absent flag stuck");

   // scenarios
   c_por_cleared: cover property (@(posedge i_clk_sys) disable iff (!rst_sync)
      $fell(o_power_on_flag));
   c_id_read: cover property (@(posedge i_clk_sys) disable iff (!rst_sync)
      i_register_read_command && i_reg_addr == ADDR_IDENTITY);
   c_rail_flag: cover property (@(posedge i_clk_sys) disable iff (!rst_sync)
      $rose(status_value[5]));
   c_ref_flag: cover property (@(posedge i_clk_sys) disable iff (!rst_sync)
      $rose(status_value[0]));
   c_set_wins: cover property (@(posedge i_clk_sys) disable iff (!rst_sync)
      i_por_event && por_clear);

endmodule : dids_regs

/* File: dids_host.sv */
// host model: issues decoded register reads and writes
// assumes a free-running clock and no command before reset release
module dids_host
(
   // clock and read answer
   input  wire logic       i_clk_sys,
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_rvalid,
   // decoded commands
   output logic            o_rd,
   output logic            o_wr,
   output logic [7:0]      o_addr,
   output logic [7:0]      o_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle lines before the first command
   initial
   begin
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end
   // one write pulse; released lines show the inverse value
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk_sys);
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask : wr_reg
   // one read pulse; answer sampled once the taken edge has settled
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge i_clk_sys);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clk_sys);
      o_rd <= 1'b0;
      o_addr <= ~a;
      #1;
      d = i_rdata;
      v = i_rvalid;
      // hand back on an edge so callers drive stimulus there
      @(posedge i_clk_sys);
   endtask : rd_reg
endmodule : dids_host

/* File: dids_regs_bench.sv */
// self-checking bench for the identification and status registers
// assumes the host model drives all register commands
`define CHK(nm, e, g) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         fails++; \
         $display("MISMATCH %s expected %h seen %h", nm, e, g); \
      end \
   end
module dids_regs_bench
   import dids_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   logic       rd_cmd, wr_cmd, rvalid, pflag, v;
   logic [7:0] addr, wdata, rdata, id0;
   logic       por_event = 1'b0;
   logic       startup_done = 1'b1;
   logic [5:0] mon = 6'h00;
   logic       rail_en = 1'b1;
   logic [1:0] ref_en = 2'b11;
   int         fails = 0;
   int         num_checks = 0;
   // 125 MHz clock
   always #4 clk_sys = ~clk_sys;
   dids_host i_host (.i_clk_sys(clk_sys), .i_rdata(rdata), .i_rvalid(rvalid),
      .o_rd(rd_cmd), .o_wr(wr_cmd), .o_addr(addr), .o_wdata(wdata));
   dids_regs i_dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
      .i_register_read_command(rd_cmd), .i_register_write_command(wr_cmd),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .i_por_event(por_event),
      .i_startup_done(startup_done), .i_pos_out_near_top_rail(mon[5]),
      .i_pos_out_near_bottom_rail(mon[4]), .i_neg_out_near_top_rail(mon[3]),
      .i_neg_out_near_bottom_rail(mon[2]), .i_reference_low_third(mon[1]),
      .i_reference_absent(mon[0]), .i_rail_monitor_enable(rail_en),
      .i_reference_monitor_enable(ref_en), .o_reg_rdata(rdata),
      .o_reg_rvalid(rvalid), .o_power_on_flag(pflag));
   // read one register and compare the whole byte
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
      logic [7:0] d;
      logic       ok;
      i_host.rd_reg(a, d, ok);
      `CHK("read valid", 1'b1, ok)
      `CHK(nm, e, d)
   endtask : rd_chk
   // reset pulse, then wait until commands are accepted
   task automatic do_reset(input int n);
      rst_n <= 1'b0;
      repeat (n) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask : do_reset
   // reset values, identity and unmapped address
   task automatic t_reset_state;
      rd_chk(ADDR_STATUS, 8'h80, "status reset");
      i_host.rd_reg(ADDR_IDENTITY, id0, v);
      `CHK("read valid", 1'b1, v)
      `CHK("model id", MODEL_ID_DEFAULT, id0[2:0])
      i_host.wr_reg(ADDR_IDENTITY, ~id0);
      rd_chk(ADDR_IDENTITY, id0, "identity after write");
      rd_chk(8'h02, 8'h00, "unmapped read");
   endtask : t_reset_state
   // clearing, event set and reset set of the power-on flag
   task automatic t_por_flag;
      i_host.wr_reg(ADDR_STATUS, 8'h7F);
      #1 `CHK("flag cleared", 1'b0, pflag)
      repeat (5) @(posedge clk_sys);
      rd_chk(ADDR_STATUS, 8'h00, "status cleared");
      @(posedge clk_sys);
      por_event <= 1'b1;
      @(posedge clk_sys);
      por_event <= 1'b0;
      #1 `CHK("flag event", 1'b1, pflag)
      i_host.wr_reg(ADDR_STATUS, 8'h80);
      rd_chk(ADDR_STATUS, 8'h80, "flag kept");
      // event and clearing write on one edge: set wins
      fork
         i_host.wr_reg(ADDR_STATUS, 8'h00);
         begin
            @(posedge clk_sys);
            por_event <= 1'b1;
            @(posedge clk_sys);
            por_event <= 1'b0;
         end
      join
      #1 `CHK("set wins", 1'b1, pflag)
      i_host.wr_reg(ADDR_STATUS, 8'h00);
      do_reset(2);
      rd_chk(ADDR_STATUS, 8'h80, "flag after reset");
      i_host.wr_reg(ADDR_STATUS, 8'h00);
   endtask : t_por_flag
   // readiness bit follows start-up state
   task automatic t_ready;
      @(posedge clk_sys);
      startup_done <= 1'b0;
      rd_chk(ADDR_STATUS, 8'h40, "not ready");
      startup_done <= 1'b1;
      rd_chk(ADDR_STATUS, 8'h00, "ready");
   endtask : t_ready
   // each monitor alone, then gating by the enables
   task automatic t_monitors;
      logic [2:0] en_tab [5];
      logic [7:0] exp_tab [5];
      en_tab = '{3'b000, 3'b100, 3'b010, 3'b001, 3'b111};
      exp_tab = '{8'h00, 8'h3C, 8'h02, 8'h01, 8'h3F};
      for (int b = 0; b < 6; b++)
      begin
         mon <= 6'h01 << b;
         repeat (4) @(posedge clk_sys);
         rd_chk(ADDR_STATUS, {2'b00, 6'h01 << b}, "monitor");
      end
      mon <= 6'h3F;
      for (int i = 0; i < 5; i++)
      begin
         {rail_en, ref_en} <= en_tab[i];
         repeat (4) @(posedge clk_sys);
         rd_chk(ADDR_STATUS, exp_tab[i], "gated monitors");
      end
      mon <= 6'h00;
      repeat (4) @(posedge clk_sys);
      rd_chk(ADDR_STATUS, 8'h00, "monitors idle");
   endtask : t_monitors
   // counts and verdict
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   // watchdog well beyond the expected run
   initial
   begin
      #(8 * 5000);
      fails++;
      report_and_stop();
   end
   // main sequence
   initial
   begin
      do_reset(12);
      t_reset_state();
      t_por_flag();
      t_ready();
      t_monitors();
      report_and_stop();
   end
endmodule : dids_regs_bench
